// *** verilog/acx_pkg.sv ***
// Constants, register map and carrier types of the converter control block.
// Assumes a byte-wide I/O space in which the block owns addresses 0x01 to 0x07.
package acx_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [5:0] OFF_DIGITAL_DISABLE_0 = 6'h01;
    localparam logic [5:0] OFF_DIGITAL_DISABLE_1 = 6'h02;
    localparam logic [5:0] OFF_CONV_CONTROL_B = 6'h03;
    localparam logic [5:0] OFF_CONV_RESULT_LOW = 6'h04;
    localparam logic [5:0] OFF_CONV_RESULT_HIGH = 6'h05;
    localparam logic [5:0] OFF_CONV_CONTROL_A = 6'h06;
    localparam logic [5:0] OFF_INPUT_SELECT = 6'h07;
    localparam logic [5:0] BIT_ACCESS_TOP = 6'h1F;

    // ----------------------------------------
    // Field positions and masks
    // ----------------------------------------
    localparam int SEL_REF_HI = 7;
    localparam int SEL_REF_LO = 6;
    localparam int SEL_LEFT_ADJUST = 5;
    localparam int CTA_ENABLE = 7;
    localparam int CTA_START = 6;
    localparam int CTA_AUTO = 5;
    localparam int CTA_DONE_FLAG = 4;
    localparam int CTA_DONE_IE = 3;
    localparam int CTB_BIPOLAR = 7;
    localparam int CTB_GAIN_RANGE = 6;
    localparam int CTB_REF_TOP = 4;
    localparam int CTB_CHAN_TOP = 3;
    localparam int DD0_REFPIN = 3;
    localparam logic [7:0] CTB_RESERVED_MASK = 8'hDF;
    localparam logic [7:0] DD1_USED_MASK = 8'hF0;

    // ----------------------------------------
    // Reset values, timing counts, channel and trigger codes
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0D;
    localparam logic [4:0] CONV_CYCLES_LONG = 5'h19;
    localparam logic [5:0] CHAN_TEMP_SENSOR = 6'h0B;
    localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        REF_SUPPLY = 3'b000,
        REF_EXTERNAL = 3'b001,
        REF_INT_1V1 = 3'b010,
        REF_RESERVED = 3'b011,
        REF_INT_2V56 = 3'b110,
        REF_INT_2V56_CAP = 3'b111
    } acx_ref_mode_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN = 2'b01
    } acx_conv_state_t;

    typedef struct packed {
        logic [5:0] addr;
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_num;
        logic [7:0] wdata;
    } acx_io_req_t;

    typedef struct packed {
        acx_ref_mode_t ref_mode;
        logic [5:0] chan;
        logic temp_sensor_en;
        logic bipolar;
        logic gain_range;
        logic conv_start;
        logic conv_long;
        logic conv_active;
        logic adc_clk_tick;
    } acx_analog_ctl_t;

    typedef struct packed {
        logic [7:0] input_select;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] dis0;
        logic [7:0] dis1;
        logic [2:0] act_ref;
        logic [5:0] act_chan;
        logic ref_changed;
        logic first_after_enable;
        acx_conv_state_t conv_state;
        logic [4:0] conv_cnt;
        logic conv_long;
        logic [6:0] prescale;
        logic [9:0] result;
        logic trig_prev;
        logic [2:0] trig_src_prev;
        logic [7:0] rdata;
    } acx_state_t;

endpackage

// *** verilog/acx_control.sv ***
// Converter control: register file, deferred selections, conversion timing,
// auto-trigger and digital input disable of the analog pins.
// Assumes a synchronous byte I/O port with single-bit set/clear strobes and an
// analog core that offers its 10-bit result when a conversion ends.
`timescale 1ns/100ps

module acx_control
    import acx_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // I/O register port
    input acx_pkg::acx_io_req_t i_io,
    output logic [7:0] o_io_rdata,
    // Analog core
    input wire logic [9:0] i_analog_result,
    output acx_pkg::acx_analog_ctl_t o_analog,
    // Trigger source flags, index = source code, bit 0 unused
    input wire logic [7:0] i_trig_flags,
    // Analog pins
    input wire logic [10:0] i_chan_pin_in,
    input wire logic i_refpin_in,
    output logic [10:0] o_chan_pin_read,
    output logic o_refpin_read,
    output logic [10:0] o_chan_buf_off,
    output logic o_refpin_buf_off,
    // Completion request level toward the interrupt controller
    output logic o_done_request
);
    import acx_pkg::*;

    acx_state_t st_ff;
    acx_state_t nxt_st;

    // ----------------------------------------
    // Write decode with single-bit operations
    // ----------------------------------------
    logic [7:0] wmask;
    logic [7:0] wval;
    logic flag_clr;
    logic bit_op;

    always_comb
    begin
        bit_op = (i_io.bit_set | i_io.bit_clr) && (i_io.addr <= BIT_ACCESS_TOP);
        wmask = 8'h00;
        wval = 8'h00;
        flag_clr = 1'b0;
        if (i_io.wr)
        begin
            wmask = 8'hFF;
            wval = i_io.wdata;
            flag_clr = i_io.wdata[CTA_DONE_FLAG];
        end
        else if (bit_op)
        begin
            // Only the addressed bit moves, so a set on a neighbour leaves the flag alone
            wmask = 8'h01 << i_io.bit_num;
            wval = i_io.bit_set ? 8'hFF : 8'h00;
            flag_clr = i_io.bit_set && (i_io.bit_num == 3'(CTA_DONE_FLAG));
        end
    end

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] m, input logic [7:0] v);
        merge = (old & ~m) | (v & m);
    endfunction

    // ----------------------------------------
    // Result presentation
    // ----------------------------------------
    logic [7:0] res_low;
    logic [7:0] res_high;

    always_comb
    begin
        // Taken straight from the stored result, so the bit acts even mid-conversion
        if (st_ff.input_select[SEL_LEFT_ADJUST])
        begin
            res_high = st_ff.result[9:2];
            res_low = {st_ff.result[1:0], 6'h00};
        end
        else
        begin
            res_high = {6'h00, st_ff.result[9:8]};
            res_low = st_ff.result[7:0];
        end
    end

    // ----------------------------------------
    // Prescaler and trigger selection
    // ----------------------------------------
    logic [2:0] ps_sel;
    logic [6:0] ps_mask;
    logic tick;
    logic [2:0] trig_src;
    logic trig_lvl;
    logic trig_edge;

    always_comb
    begin
        ps_sel = st_ff.ctrl_a[2:0];
        ps_mask = (ps_sel == 3'h0) ? 7'h01 : 7'((8'h01 << ps_sel) - 8'h01);
        tick = st_ff.ctrl_a[CTA_ENABLE] && ((st_ff.prescale & ps_mask) == ps_mask);
        trig_src = st_ff.ctrl_b[2:0];
        // Code 0 follows the block's own completion flag, others the external flags
        trig_lvl = (trig_src == TRIG_FREE_RUN) ? st_ff.ctrl_a[CTA_DONE_FLAG]
                                               : i_trig_flags[trig_src];
        trig_edge = trig_lvl && !st_ff.trig_prev
                    && !((trig_src == TRIG_FREE_RUN) && (st_ff.trig_src_prev != TRIG_FREE_RUN));
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic conv_end;
    logic sw_start;
    logic auto_start;
    logic start;
    logic [2:0] pend_ref;
    logic [5:0] pend_chan;
    logic [4:0] conv_len;
    logic [7:0] new_a;

    always_comb
    begin
        nxt_st = st_ff;
        conv_end = 1'b0;
        start = 1'b0;

        // Register writes
        if (i_io.addr == OFF_INPUT_SELECT)
        begin
            nxt_st.input_select = merge(st_ff.input_select, wmask, wval);
        end
        if (i_io.addr == OFF_CONV_CONTROL_B)
        begin
            nxt_st.ctrl_b = merge(st_ff.ctrl_b, wmask, wval) & CTB_RESERVED_MASK;
        end
        if (i_io.addr == OFF_DIGITAL_DISABLE_0)
        begin
            nxt_st.dis0 = merge(st_ff.dis0, wmask, wval);
        end
        if (i_io.addr == OFF_DIGITAL_DISABLE_1)
        begin
            nxt_st.dis1 = merge(st_ff.dis1, wmask, wval) & DD1_USED_MASK;
        end
        new_a = st_ff.ctrl_a;
        sw_start = 1'b0;
        if (i_io.addr == OFF_CONV_CONTROL_A)
        begin
            new_a = merge(st_ff.ctrl_a, wmask, wval);
            sw_start = new_a[CTA_START] && (wmask[CTA_START] == 1'b1);
            new_a[CTA_DONE_FLAG] = st_ff.ctrl_a[CTA_DONE_FLAG] && !flag_clr;
        end
        new_a[CTA_START] = 1'b0;
        nxt_st.ctrl_a = new_a;

        // Prescaler runs only while the converter is enabled
        nxt_st.prescale = st_ff.ctrl_a[CTA_ENABLE] ? 7'(st_ff.prescale + 7'h01) : 7'h00;

        // Conversion sequencing
        conv_len = st_ff.conv_long ? CONV_CYCLES_LONG : CONV_CYCLES_NORMAL;
        case (st_ff.conv_state)
            CONV_IDLE:
            begin
                nxt_st.conv_cnt = 5'h00;
            end
            CONV_RUN:
            begin
                if (!st_ff.ctrl_a[CTA_ENABLE])
                begin
                    nxt_st.conv_state = CONV_IDLE;
                end
                else if (tick)
                begin
                    if (st_ff.conv_cnt == 5'(conv_len - 5'h01))
                    begin
                        conv_end = 1'b1;
                        nxt_st.conv_state = CONV_IDLE;
                        nxt_st.result = i_analog_result;
                    end
                    else
                    begin
                        nxt_st.conv_cnt = 5'(st_ff.conv_cnt + 5'h01);
                    end
                end
            end
            default:
            begin
                nxt_st.conv_state = CONV_IDLE;
            end
        endcase
        // A completion in the same cycle as a clear keeps the flag set
        if (conv_end)
        begin
            nxt_st.ctrl_a[CTA_DONE_FLAG] = 1'b1;
        end

        // Deferred selections: copied while idle or on the completion cycle
        pend_ref = {nxt_st.ctrl_b[CTB_REF_TOP], nxt_st.input_select[SEL_REF_HI:SEL_REF_LO]};
        pend_chan = {nxt_st.ctrl_b[CTB_CHAN_TOP], nxt_st.input_select[4:0]};
        if ((st_ff.conv_state == CONV_IDLE) || conv_end)
        begin
            nxt_st.act_ref = pend_ref;
            nxt_st.act_chan = pend_chan;
            if (pend_ref != st_ff.act_ref)
            begin
                nxt_st.ref_changed = 1'b1;
            end
        end

        if (!st_ff.ctrl_a[CTA_ENABLE])
        begin
            nxt_st.first_after_enable = 1'b1;
        end

        // Start: software bit, or a trigger edge only while auto-trigger is on
        auto_start = st_ff.ctrl_a[CTA_AUTO] && trig_edge;
        if (st_ff.ctrl_a[CTA_ENABLE] && (sw_start || auto_start) && (nxt_st.conv_state == CONV_IDLE)
            && !conv_end)
        begin
            start = 1'b1;
            nxt_st.conv_state = CONV_RUN;
            nxt_st.conv_cnt = 5'h00;
            nxt_st.conv_long = nxt_st.ref_changed || st_ff.first_after_enable;
            nxt_st.ref_changed = 1'b0;
            nxt_st.first_after_enable = 1'b0;
        end

        nxt_st.trig_prev = trig_lvl;
        nxt_st.trig_src_prev = trig_src;

        // Registered read data, test of single bits uses the same path
        if (i_io.rd)
        begin
            case (i_io.addr)
                OFF_DIGITAL_DISABLE_0: nxt_st.rdata = st_ff.dis0;
                OFF_DIGITAL_DISABLE_1: nxt_st.rdata = st_ff.dis1;
                OFF_CONV_CONTROL_B: nxt_st.rdata = st_ff.ctrl_b;
                OFF_CONV_RESULT_LOW: nxt_st.rdata = res_low;
                OFF_CONV_RESULT_HIGH: nxt_st.rdata = res_high;
                OFF_CONV_CONTROL_A:
                    nxt_st.rdata = st_ff.ctrl_a | ((st_ff.conv_state == CONV_RUN) ? 8'h40 : 8'h00);
                OFF_INPUT_SELECT: nxt_st.rdata = st_ff.input_select;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [10:0] chan_off;

    always_comb
    begin
        chan_off = {st_ff.dis1[7:4], st_ff.dis0[7:4], st_ff.dis0[2:0]};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++)
        begin : g_pin
            assign o_chan_pin_read[gi] = i_chan_pin_in[gi] & ~chan_off[gi];
        end
    endgenerate

    assign o_chan_buf_off = chan_off;
    assign o_refpin_buf_off = st_ff.dis0[DD0_REFPIN];
    assign o_refpin_read = i_refpin_in & ~st_ff.dis0[DD0_REFPIN];
    assign o_io_rdata = st_ff.rdata;
    assign o_done_request = st_ff.ctrl_a[CTA_DONE_FLAG] & st_ff.ctrl_a[CTA_DONE_IE];

    always_comb
    begin
        // Reserved code 3'b011 is forwarded unchanged; the core decides what it does
        o_analog.ref_mode = acx_ref_mode_t'(st_ff.act_ref);
        // Every code goes through, including a pin paired with itself for offset
        o_analog.chan = st_ff.act_chan;
        o_analog.temp_sensor_en = (st_ff.act_chan == CHAN_TEMP_SENSOR);
        o_analog.bipolar = st_ff.ctrl_b[CTB_BIPOLAR];
        o_analog.gain_range = st_ff.ctrl_b[CTB_GAIN_RANGE];
        o_analog.conv_start = (st_ff.conv_state == CONV_RUN) && (st_ff.conv_cnt == 5'h00) && tick;
        o_analog.conv_long = st_ff.conv_long;
        o_analog.conv_active = (st_ff.conv_state == CONV_RUN);
        o_analog.adc_clk_tick = tick;
    end

endmodule

// *** dv/acx_control_properties.sv ***
// Port checker of the converter control block.
// Assumes it is bound into acx_control and sees only its ports.
`timescale 1ns/100ps

module acx_control_properties
    import acx_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input acx_pkg::acx_io_req_t i_io,
    input acx_pkg::acx_analog_ctl_t o_analog,
    input wire logic [10:0] i_chan_pin_in,
    input wire logic i_refpin_in,
    input wire logic [10:0] o_chan_pin_read,
    input wire logic o_refpin_read,
    input wire logic [10:0] o_chan_buf_off,
    input wire logic o_refpin_buf_off
);
    logic busy;
    logic [7:0] sel_q_ff;
    assign busy = o_analog.conv_active;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Last byte written to input_select, for the idle copy check
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            sel_q_ff <= 8'h00;
        else if (i_io.wr && i_io.addr == OFF_INPUT_SELECT)
            sel_q_ff <= i_io.wdata;
    end

    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence sel_wr_s;
        i_io.wr && i_io.addr == OFF_INPUT_SELECT && !busy;
    endsequence
    sequence quiet_s;
        !busy && !((i_io.wr || i_io.bit_set || i_io.bit_clr) && i_io.addr == OFF_INPUT_SELECT);
    endsequence

    temp_route_a: assert property (
        o_analog.temp_sensor_en == (o_analog.chan == CHAN_TEMP_SENSOR)) else $error("temp sensor route wrong");
    pin_gate_a: assert property (
        o_chan_pin_read == (i_chan_pin_in & ~o_chan_buf_off)) else $error("channel pin read not gated");
    refpin_gate_a: assert property (
        o_refpin_read == (i_refpin_in & ~o_refpin_buf_off)) else $error("reference pin read not gated");
    ref_busy_a: assert property (
        busy && $past(busy) |-> $stable(o_analog.ref_mode)) else $error("reference moved mid conversion");
    chan_busy_a: assert property (
        busy && $past(busy) |-> $stable(o_analog.chan)) else $error("channel moved mid conversion");
    dis0_map_a: assert property (
        i_io.wr && i_io.addr == OFF_DIGITAL_DISABLE_0 |=>
        {o_chan_buf_off[6:3], o_refpin_buf_off, o_chan_buf_off[2:0]} == $past(i_io.wdata)) else $error("disable 0 map");
    dis1_map_a: assert property (
        i_io.wr && i_io.addr == OFF_DIGITAL_DISABLE_1 |=>
        o_chan_buf_off[10:7] == $past(i_io.wdata[7:4])) else $error("disable 1 map");
    refpin_set_a: assert property (
        i_io.bit_set && !i_io.wr && i_io.addr == OFF_DIGITAL_DISABLE_0 && i_io.bit_num == 3'h3 |=>
        o_refpin_buf_off) else $error("bit set missed reference pin");
    bitop_keep_a: assert property (
        (i_io.bit_set || i_io.bit_clr) && !i_io.wr && i_io.addr == OFF_CONV_CONTROL_B && i_io.bit_num != 3'h7
        |=> $stable(o_analog.bipolar)) else $error("bit op touched another bit");
    idle_copy_a: assert property (
        sel_wr_s ##1 quiet_s |=> o_analog.chan[4:0] == sel_q_ff[4:0] && o_analog.ref_mode[1:0] == sel_q_ff[7:6])
        else $error("idle selection not copied");
endmodule

bind acx_control acx_control_properties chk_u (.i_clk, .i_rst, .i_io, .o_analog, .i_chan_pin_in, .i_refpin_in,
    .o_chan_pin_read, .o_refpin_read, .o_chan_buf_off, .o_refpin_buf_off);

// *** dv/acx_core_model.sv ***
// Behavioural analog core: result built from the selection at conversion start.
// Assumes the control block samples the result in the cycle a conversion ends.
`timescale 1ns/100ps

module acx_core_model
    import acx_pkg::*;
#(
    parameter logic [9:0] TEMP_CODE = 10'h144
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input acx_pkg::acx_analog_ctl_t i_ctl,
    output logic [9:0] o_result
);
    logic [9:0] val_ff;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            val_ff <= 10'h000;
        else if (i_ctl.conv_start)
            val_ff <= i_ctl.temp_sensor_en ? TEMP_CODE : {2'h2, i_ctl.chan, 2'h1};
    end

    // Outside a conversion the value is scrambled so a stale sample shows
    assign o_result = i_ctl.conv_active ? val_ff : ~val_ff;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench of the converter control block.
// Assumes the core model on the analog side and inputs driven at falling edges.
`timescale 1ns/100ps

module testbench;
    import acx_pkg::*;
    logic i_clk;
    logic i_rst;
    acx_io_req_t io;
    logic [7:0] o_io_rdata;
    logic [9:0] res;
    acx_analog_ctl_t o_analog;
    logic [7:0] flags;
    logic [10:0] pins;
    logic refin;
    logic [10:0] o_chan_pin_read;
    logic o_refpin_read;
    logic o_done_request;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    acx_control dut_u (.i_clk, .i_rst, .i_io(io), .o_io_rdata, .i_analog_result(res), .o_analog,
        .i_trig_flags(flags), .i_chan_pin_in(pins), .i_refpin_in(refin), .o_chan_pin_read, .o_refpin_read,
        .o_chan_buf_off(), .o_refpin_buf_off(), .o_done_request);
    acx_core_model core_u (.i_clk, .i_rst, .i_ctl(o_analog), .o_result(res));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask

    // Each access lets one edge pass first, so a strobe is never lowered and raised in one step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clk);
        io.addr = a;
        io.wdata = d;
        io.wr = 1'b1;
        @(negedge i_clk);
        io.wr = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge i_clk);
        io.addr = a;
        io.rd = 1'b1;
        @(negedge i_clk);
        io.rd = 1'b0;
        chk(o_io_rdata, e);
    endtask

    task automatic bop(input logic s, input logic [5:0] a, input logic [2:0] b);
        @(negedge i_clk);
        io.addr = a;
        io.bit_num = b;
        io.bit_set = s;
        io.bit_clr = !s;
        @(negedge i_clk);
        io.bit_set = 1'b0;
        io.bit_clr = 1'b0;
    endtask

    // Waits for a start, then counts converter ticks; zero means none began
    task automatic run(input logic [15:0] exp);
        logic [15:0] n;
        logic [15:0] t;
        n = 0;
        t = 0;
        while (o_analog.conv_active !== 1'b1 && n < 20)
        begin
            @(negedge i_clk);
            n++;
        end
        while (o_analog.conv_active === 1'b1 && n < 3000)
        begin
            if (o_analog.adc_clk_tick === 1'b1)
                t++;
            @(negedge i_clk);
            n++;
        end
        chk(t, exp);
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            num_errors++;
            print_verdict;
        end
    end

    initial
    begin
        i_rst = 1'b1;
        io = '0;
        flags = 8'h00;
        pins = 11'h7FF;
        refin = 1'b1;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        for (int a = 1; a < 9; a++)
            rd(6'(a), 8'h00);
        wr(OFF_DIGITAL_DISABLE_0, 8'hA5);
        wr(OFF_DIGITAL_DISABLE_1, 8'hF0);
        rd(OFF_DIGITAL_DISABLE_0, 8'hA5);
        rd(OFF_DIGITAL_DISABLE_1, 8'hF0);
        chk(o_chan_pin_read, 11'h02A);
        chk(o_refpin_read, 1'b1);
        bop(1'b1, OFF_DIGITAL_DISABLE_0, 3'h3);
        chk(o_refpin_read, 1'b0);
        rd(OFF_DIGITAL_DISABLE_0, 8'hAD);
        bop(1'b0, OFF_DIGITAL_DISABLE_0, 3'h0);
        chk(o_chan_pin_read, 11'h02B);
        wr(OFF_CONV_CONTROL_B, 8'hDF);
        bop(1'b0, OFF_CONV_CONTROL_B, 3'h6);
        rd(OFF_CONV_CONTROL_B, 8'h9F);
        chk(o_analog.bipolar, 1'b1);
        chk(o_analog.gain_range, 1'b0);
        wr(OFF_CONV_CONTROL_B, 8'h00);
        wr(OFF_INPUT_SELECT, 8'h05);
        // Enable first: a start bit counts only once enable already stands
        wr(OFF_CONV_CONTROL_A, 8'h80);
        wr(OFF_CONV_CONTROL_A, 8'hC0);
        run(16'd25);
        rd(OFF_CONV_CONTROL_A, 8'h90);
        rd(OFF_CONV_RESULT_HIGH, 8'h02);
        rd(OFF_CONV_RESULT_LOW, 8'h15);
        wr(OFF_INPUT_SELECT, 8'h25);
        rd(OFF_CONV_RESULT_HIGH, 8'h85);
        rd(OFF_CONV_RESULT_LOW, 8'h40);
        wr(OFF_CONV_CONTROL_A, 8'h90);
        rd(OFF_CONV_CONTROL_A, 8'h80);
        wr(OFF_CONV_CONTROL_A, 8'hC0);
        // Selection rewritten mid-conversion while every tick is still counted
        fork
            run(16'd13);
            begin
                repeat (4) @(negedge i_clk);
                wr(OFF_INPUT_SELECT, 8'h4B);
                chk(o_analog.chan, 6'h05);
                chk(o_analog.ref_mode, REF_SUPPLY);
            end
        join
        repeat (2) @(negedge i_clk);
        chk(o_analog.chan, 6'h0B);
        chk(o_analog.temp_sensor_en, 1'b1);
        chk(o_analog.ref_mode, REF_EXTERNAL);
        wr(OFF_CONV_CONTROL_A, 8'hC0);
        run(16'd25);
        rd(OFF_CONV_RESULT_HIGH, 8'h01);
        rd(OFF_CONV_RESULT_LOW, 8'h44);
        wr(OFF_CONV_CONTROL_A, 8'h90);
        wr(OFF_CONV_CONTROL_B, 8'h05);
        flags = 8'h20;
        run(16'd0);
        flags = 8'h00;
        for (int c = 1; c < 8; c++)
        begin
            wr(OFF_CONV_CONTROL_B, 8'(c));
            wr(OFF_CONV_CONTROL_A, 8'hB0);
            flags = 8'h01 << c;
            run(16'd13);
            run(16'd0);
            flags = 8'h00;
        end
        flags = 8'h10;
        wr(OFF_CONV_CONTROL_B, 8'h04);
        run(16'd13);
        // Old source low, so only the free-running guard can hold the edge back
        flags = 8'h00;
        wr(OFF_CONV_CONTROL_B, 8'h00);
        run(16'd0);
        bop(1'b1, OFF_CONV_CONTROL_A, 3'h3);
        chk(o_done_request, 1'b1);
        wr(OFF_CONV_CONTROL_A, 8'h80);
        wr(OFF_CONV_CONTROL_B, 8'h10);
        wr(OFF_INPUT_SELECT, 8'hC0);
        repeat (2) @(negedge i_clk);
        chk(o_analog.ref_mode, REF_INT_2V56_CAP);
        print_verdict;
    end
endmodule
